/* File: gpc_defs.svh */
// gpc_defs.svh: register offsets, field positions, reset values and timing of the 1G PCS control block
// assumes a 32-bit classic wishbone slave with byte addresses and a 20 MHz clock
`ifndef GPC_DEFS_SVH
`define GPC_DEFS_SVH
`define GPC_CLK_KHZ 20000
`define GPC_LT_SGMII_US 1600
`define GPC_LT_SERDES_US 10000
`define GPC_QUIET_CYC 400
`define GPC_REFRESH_CYC 40
`define GPC_REG_CFG 8'h00
`define GPC_REG_SD 8'h04
`define GPC_REG_AN_CFG 8'h08
`define GPC_REG_NP_CFG 8'h0c
`define GPC_REG_AN_STAT 8'h10
`define GPC_REG_NP_STAT 8'h14
`define GPC_REG_LINK 8'h18
`define GPC_REG_DOWN_CNT 8'h1c
`define GPC_REG_STICKY 8'h20
`define GPC_REG_TP_CFG 8'h24
`define GPC_REG_TP_STAT 8'h28
`define GPC_REG_LPI_CFG 8'h2c
`define GPC_REG_LPI_STAT 8'h30
`define GPC_REG_WAKE_CNT 8'h34
`define GPC_CFG_MASK 32'h0000000f
`define GPC_SD_MASK 32'h00000007
`define GPC_AN_MASK 32'hffff0001
`define GPC_NP_MASK 32'hffff0000
`define GPC_TP_MASK 32'h00000007
`define GPC_LPI_MASK 32'h00000001
`define GPC_CFG_RST 32'h00000000
`define GPC_SD_RST 32'h00000002
`define GPC_AN_RST 32'h00000000
`define GPC_B_ENA 0
`define GPC_B_SGMII 1
`define GPC_B_ONE_WAY 2
`define GPC_B_LOOP 3
`define GPC_B_DETECT_ENABLE 0
`define GPC_B_DETECT_POLARITY 1
`define GPC_B_DETECT_SOURCE_SELECT 2
`define GPC_B_RESTART 1
`define GPC_B_LOADED 0
`define GPC_B_PAGE_FLAG 1
`define GPC_B_PAGE_LINK 15
`define GPC_B_NEXT_PAGE 15
`define GPC_B_RX_FLAG 4
`define GPC_B_TX_FLAG 5
`define GPC_PAT_HIGH 10'h2aa
`define GPC_PAT_LOW 10'h3e0
`define GPC_PAT_COMMA_N 10'h0fa
`define GPC_PAT_COMMA_P 10'h305
`define GPC_LFSR_SEED 10'h3ff
`define GPC_FRAME_LONG 10'h3ff
`define GPC_FRAME_SHORT 10'h03f
`endif

/* File: gpc_pkg.sv */
// gpc_pkg.sv: types of the 1G PCS control block
// assumes nothing beyond a SystemVerilog compiler
package gpc_pkg;
  typedef enum logic [2:0] {tk_idle, tk_data, tk_cfg, tk_lpi, tk_pattern} gpc_tx_kind_t;
  typedef enum logic [2:0] {st_neg_off, st_neg_off_link_ok, st_restart, st_ability, st_np_wait,
    st_np_xchg, st_idle_detect, st_link_ok} gpc_an_t;
  typedef struct packed {
    gpc_tx_kind_t kind;
    logic [15:0] word;
  } gpc_tx_t;
endpackage

/* File: gpc_pcs_ctrl.sv */
// gpc_pcs_ctrl.sv: control and status of a 1G PCS with negotiation, surveillance, test patterns, EEE
// assumes the code-group datapath around it reports sync, config words and idle symbols on clk_i
//
// Our own choices: the Wishbone interface to the registers and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "gpc_defs.svh"
module gpc_pcs_ctrl import gpc_pkg::*; #(
  parameter int unsigned P_LT_SGMII_CYC = `GPC_LT_SGMII_US * `GPC_CLK_KHZ / 1000,
  parameter int unsigned P_LT_SERDES_CYC = `GPC_LT_SERDES_US * `GPC_CLK_KHZ / 1000,
  parameter int unsigned P_QUIET_CYC = `GPC_QUIET_CYC,
  parameter int unsigned P_REFRESH_CYC = `GPC_REFRESH_CYC,
  parameter int P_CNT_W = 16
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic wb_ack_o,
  output logic [31:0] wb_dat_o,
  // receive side reports
  input wire logic rx_sync_i,
  input wire logic rx_cfg_valid_i,
  input wire logic [15:0] rx_cfg_word_i,
  input wire logic rx_lpi_i,
  input wire logic rx_code_valid_i,
  input wire logic [9:0] rx_code_i,
  // signal detect sources and queue system
  input wire logic sd_pma_i,
  input wire logic sd_pmd_i,
  input wire logic mac_tx_lpi_i,
  // datapath control
  output gpc_tx_t tx_o,
  output logic tx_data_enable_o,
  output logic tx_serdes_stop_o,
  output logic loop_o,
  output logic rx_restart_o,
  output logic rx_frame_enable_o,
  output logic link_o
);
  logic [31:0] cfg, sd, an, np, tp, lpi, be_m, rdata;
  logic [15:0] partner_base_word, partner_next_page_word;
  logic [P_CNT_W-1:0] link_lost_counter, wake_error_counter;
  logic [31:0] lt_cnt, dn_cnt, lt_lim, q_cnt;
  logic [9:0] lfsr, frm_cnt, next_pat;
  logic [7:0] tp_err;
  logic [1:0] tp_match;
  logic wr, rd, restart_p, loaded_p, en, sgmii, neg_en, sync_r, det_src, det_ok, det_q, sd_loss;
  logic page_flag, link_down_flag, link_down_p, lt_done, np_want, tp_lock, rx_ok_st;
  logic rx_idle_power_mode, rx_quiet, tx_idle_power_mode, tx_quiet, rx_flag, tx_flag, mix_ph;
  gpc_an_t an_st, next_an;
  gpc_tx_t next_tx;

  // bus decode and byte lanes
  assign wr = wb_cyc_i & wb_stb_i & wb_we_i & ~wb_ack_o;
  assign rd = wb_cyc_i & wb_stb_i & ~wb_we_i & ~wb_ack_o;
  for (genvar b = 0; b < 4; b++) begin : g_lane
    assign be_m[8*b +: 8] = {8{wb_sel_i[b]}};
  end
  assign restart_p = wr & (wb_adr_i == `GPC_REG_AN_CFG) & wb_sel_i[0] & wb_dat_i[`GPC_B_RESTART];
  assign loaded_p = wr & (wb_adr_i == `GPC_REG_NP_CFG) & wb_sel_i[0] & wb_dat_i[`GPC_B_LOADED];

  function automatic logic w1c(input logic [7:0] adr, input int bit_no);
    return wr && wb_adr_i == adr && be_m[bit_no] && wb_dat_i[bit_no];
  endfunction

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cfg <= `GPC_CFG_RST;
      sd <= `GPC_SD_RST;
      an <= `GPC_AN_RST;
      np <= 32'h00000000;
      tp <= 32'h00000000;
      lpi <= 32'h00000000;
    end else if (wr) begin
      case (wb_adr_i)
        `GPC_REG_CFG: cfg <= ((cfg & ~be_m) | (wb_dat_i & be_m)) & `GPC_CFG_MASK;
        `GPC_REG_SD: sd <= ((sd & ~be_m) | (wb_dat_i & be_m)) & `GPC_SD_MASK;
        `GPC_REG_AN_CFG: an <= ((an & ~be_m) | (wb_dat_i & be_m)) & `GPC_AN_MASK;
        `GPC_REG_NP_CFG: np <= ((np & ~be_m) | (wb_dat_i & be_m)) & `GPC_NP_MASK;
        `GPC_REG_TP_CFG: tp <= ((tp & ~be_m) | (wb_dat_i & be_m)) & `GPC_TP_MASK;
        `GPC_REG_LPI_CFG: lpi <= ((lpi & ~be_m) | (wb_dat_i & be_m)) & `GPC_LPI_MASK;
        default: ;
      endcase
    end
  end

  // read mux
  always_comb begin
    rdata = 32'h00000000;
    case (wb_adr_i)
      `GPC_REG_CFG: rdata = cfg;
      `GPC_REG_SD: rdata = sd;
      `GPC_REG_AN_CFG: rdata = an;
      `GPC_REG_NP_CFG: rdata = np;
      `GPC_REG_AN_STAT: rdata = {partner_base_word, 13'h0000, an_st inside {st_idle_detect, st_link_ok},
        page_flag, an_st == st_link_ok};
      `GPC_REG_NP_STAT: rdata = {16'h0000, partner_next_page_word};
      `GPC_REG_LINK: rdata = {29'h00000000, det_ok, sync_r, link_o};
      `GPC_REG_DOWN_CNT: rdata = 32'(link_lost_counter);
      `GPC_REG_STICKY: rdata = {31'h00000000, link_down_flag};
      `GPC_REG_TP_CFG: rdata = tp;
      `GPC_REG_TP_STAT: rdata = {16'h0000, tp_err, 7'h00, tp_lock};
      `GPC_REG_LPI_CFG: rdata = lpi;
      `GPC_REG_LPI_STAT: rdata = {26'h0000000, tx_flag, rx_flag, tx_quiet, tx_idle_power_mode,
        rx_quiet, rx_idle_power_mode};
      `GPC_REG_WAKE_CNT: rdata = 32'(wake_error_counter);
      default: rdata = 32'h00000000;
    endcase
  end

  // one-cycle ack, unmapped reads return zero
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end else begin
      wb_ack_o <= wr | rd;
      wb_dat_o <= rd ? rdata : 32'h00000000;
    end
  end

  assign en = cfg[`GPC_B_ENA];
  assign sgmii = cfg[`GPC_B_SGMII];
  assign neg_en = an[0];
  assign lt_lim = sgmii ? P_LT_SGMII_CYC : P_LT_SERDES_CYC;
  assign det_src = sd[`GPC_B_DETECT_SOURCE_SELECT] ? sd_pmd_i : sd_pma_i;
  assign det_ok = sd[`GPC_B_DETECT_POLARITY] ? det_src : ~det_src;
  assign sd_loss = sd[`GPC_B_DETECT_ENABLE] & ~det_ok;
  assign np_want = ~sgmii & an[16 + `GPC_B_NEXT_PAGE] & rx_cfg_word_i[`GPC_B_NEXT_PAGE];
  assign lt_done = lt_cnt == lt_lim - 32'd1;
  assign rx_ok_st = an_st inside {st_neg_off_link_ok, st_link_ok};

  // sync, detect and receive control
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sync_r <= 1'b0;
      det_q <= 1'b0;
      rx_restart_o <= 1'b0;
      rx_frame_enable_o <= 1'b0;
      loop_o <= 1'b0;
      link_o <= 1'b0;
    end else begin
      sync_r <= en & rx_sync_i & ~sd_loss;
      det_q <= det_ok;
      rx_restart_o <= en & sd_loss;
      rx_frame_enable_o <= en & ~sd_loss & sync_r;
      loop_o <= en & cfg[`GPC_B_LOOP];
      link_o <= (sgmii & neg_en) ? partner_base_word[`GPC_B_PAGE_LINK] & sync_r : sync_r;
    end
  end

  // negotiation state machine
  always_comb begin
    next_an = an_st;
    if (!en || !neg_en) begin
      next_an = sync_r ? st_neg_off_link_ok : st_neg_off;
    end else if (restart_p || (!sync_r && an_st != st_restart)) begin
      next_an = st_restart;
    end else begin
      case (an_st)
        st_neg_off, st_neg_off_link_ok: next_an = st_restart;
        st_restart: if (sync_r) next_an = st_ability;
        st_ability: if (rx_cfg_valid_i) next_an = np_want ? st_np_wait : st_idle_detect;
        st_np_wait: if (loaded_p) next_an = st_np_xchg;
        st_np_xchg: if (rx_cfg_valid_i) next_an = np[16 + `GPC_B_NEXT_PAGE] ? st_np_wait : st_idle_detect;
        st_idle_detect: if (lt_done) next_an = st_link_ok;
        st_link_ok: next_an = st_link_ok;
        default: next_an = st_restart;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      an_st <= st_neg_off;
      lt_cnt <= 32'd0;
    end else begin
      an_st <= next_an;
      lt_cnt <= (an_st == st_idle_detect && next_an == st_idle_detect) ? lt_cnt + 32'd1 : 32'd0;
    end
  end

  // partner pages
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      partner_base_word <= 16'h0000;
      partner_next_page_word <= 16'h0000;
      page_flag <= 1'b0;
    end else begin
      if (an_st == st_ability && next_an != st_restart && rx_cfg_valid_i) partner_base_word <= rx_cfg_word_i;
      if (an_st == st_np_xchg && next_an != st_restart && rx_cfg_valid_i) partner_next_page_word <= rx_cfg_word_i;
      page_flag <= ((an_st inside {st_ability, st_np_xchg}) && next_an != st_restart && rx_cfg_valid_i) |
        (page_flag & ~w1c(`GPC_REG_AN_STAT, `GPC_B_PAGE_FLAG));
    end
  end

  // link-down surveillance
  assign link_down_p = en && !rx_ok_st && dn_cnt == lt_lim - 32'd1;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dn_cnt <= 32'd0;
      link_down_flag <= 1'b0;
      link_lost_counter <= '0;
    end else begin
      dn_cnt <= (en && !rx_ok_st && !link_down_p) ? dn_cnt + 32'd1 : 32'd0;
      link_down_flag <= link_down_p | (link_down_flag & ~w1c(`GPC_REG_STICKY, 0));
      if (link_down_p && link_lost_counter != '1) link_lost_counter <= link_lost_counter + 1'b1;
    end
  end

  // jitter patterns
  always_comb begin
    case (tp[2:0])
      3'h1: next_pat = `GPC_PAT_HIGH;
      3'h2: next_pat = `GPC_PAT_LOW;
      3'h3: next_pat = mix_ph ? `GPC_PAT_COMMA_P : `GPC_PAT_COMMA_N;
      3'h4: next_pat = (frm_cnt == `GPC_FRAME_LONG) ? `GPC_PAT_COMMA_N : lfsr;
      3'h5: next_pat = (frm_cnt[5:0] == `GPC_FRAME_SHORT) ? `GPC_PAT_COMMA_N : lfsr;
      default: next_pat = 10'h000;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i || tp[2:0] == 3'h0) begin
      lfsr <= `GPC_LFSR_SEED;
      frm_cnt <= 10'h000;
      mix_ph <= 1'b0;
      tp_match <= 2'h0;
      tp_lock <= 1'b0;
      tp_err <= 8'h00;
    end else begin
      lfsr <= {lfsr[8:0], lfsr[9] ^ lfsr[6]};
      frm_cnt <= frm_cnt + 10'h001;
      mix_ph <= ~mix_ph;
      if (rx_code_valid_i && rx_code_i == tx_o.word[9:0]) begin
        tp_match <= (tp_match == 2'h3) ? tp_match : tp_match + 2'h1;
        tp_lock <= tp_lock | (tp_match == 2'h3);
      end else if (rx_code_valid_i) begin
        tp_match <= 2'h0;
        tp_lock <= 1'b0;
        if (tp_lock && tp_err != 8'hff) tp_err <= tp_err + 8'h01;
      end
    end
  end

  // transmit selection
  always_comb begin
    next_tx = '{kind: tk_idle, word: 16'h0000};
    if (!en) begin
      next_tx.kind = tk_idle;
    end else if (tp[2:0] != 3'h0) begin
      next_tx = '{kind: tk_pattern, word: {6'h00, next_pat}};
    end else if (tx_idle_power_mode) begin
      next_tx.kind = tx_quiet ? tk_idle : tk_lpi;
    end else if (an_st inside {st_restart, st_ability, st_np_wait}) begin
      next_tx = '{kind: tk_cfg, word: an_st == st_restart ? 16'h0000 : an[31:16]};
    end else if (an_st == st_np_xchg) begin
      next_tx = '{kind: tk_cfg, word: np[31:16]};
    end else if (cfg[`GPC_B_ONE_WAY] || rx_ok_st) begin
      next_tx.kind = tk_data;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tx_o <= '{kind: tk_idle, word: 16'h0000};
      tx_data_enable_o <= 1'b0;
      tx_serdes_stop_o <= 1'b0;
    end else begin
      tx_o <= next_tx;
      tx_data_enable_o <= next_tx.kind == tk_data;
      tx_serdes_stop_o <= en & tx_idle_power_mode & tx_quiet;
    end
  end

  // low power idle tracking
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tx_idle_power_mode <= 1'b0;
      tx_quiet <= 1'b0;
      q_cnt <= 32'd0;
      rx_idle_power_mode <= 1'b0;
      rx_quiet <= 1'b0;
      rx_flag <= 1'b0;
      tx_flag <= 1'b0;
      wake_error_counter <= '0;
    end else begin
      tx_idle_power_mode <= en & (lpi[0] | mac_tx_lpi_i);
      if (!tx_idle_power_mode) begin
        tx_quiet <= 1'b0;
        q_cnt <= 32'd0;
      end else if (q_cnt == (tx_quiet ? P_QUIET_CYC : P_REFRESH_CYC) - 32'd1) begin
        tx_quiet <= ~tx_quiet;
        q_cnt <= 32'd0;
      end else begin
        q_cnt <= q_cnt + 32'd1;
      end
      if (rx_lpi_i) rx_idle_power_mode <= 1'b1;
      else if (rx_sync_i && det_ok) rx_idle_power_mode <= 1'b0;
      rx_quiet <= (rx_idle_power_mode | rx_lpi_i) & ~det_ok;
      rx_flag <= rx_lpi_i | (rx_flag & ~w1c(`GPC_REG_LPI_STAT, `GPC_B_RX_FLAG));
      tx_flag <= (next_tx.kind == tk_lpi) | (tx_flag & ~w1c(`GPC_REG_LPI_STAT, `GPC_B_TX_FLAG));
      if (det_ok && !det_q && !sync_r && wake_error_counter != '1) wake_error_counter <= wake_error_counter + 1'b1;
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  property p_off_idle;
    !en |=> tx_o.kind == tk_idle && !tx_data_enable_o;
  endproperty
  a_off_idle: assert property (p_off_idle) else $error("disabled sublayer transmits");
  property p_one_way;
    en && cfg[`GPC_B_ONE_WAY] && tp[2:0] == 3'h0 && !tx_idle_power_mode && an_st == st_neg_off |=> tx_data_enable_o;
  endproperty
  a_one_way: assert property (p_one_way) else $error("one-way mode blocked data");
  property p_restart;
    restart_p && en && neg_en |=> an_st == st_restart ##1 tx_o.kind == tk_cfg;
  endproperty
  a_restart: assert property (p_restart) else $error("restart pulse ignored");
  property p_base;
    an_st == st_ability && next_an != st_restart && rx_cfg_valid_i |=>
      page_flag && partner_base_word == $past(rx_cfg_word_i);
  endproperty
  a_base: assert property (p_base) else $error("partner base word not captured");
  property p_np;
    an_st == st_np_wait && loaded_p && en && neg_en && sync_r |=> an_st == st_np_xchg ##1 tx_o.word == np[31:16];
  endproperty
  a_np: assert property (p_np) else $error("next page not sent");
  property p_link_ok;
    an_st == st_idle_detect && next_an == st_link_ok |-> lt_cnt == lt_lim - 32'd1;
  endproperty
  a_link_ok: assert property (p_link_ok) else $error("link-ok reached at wrong time");
  property p_down;
    link_down_p && link_lost_counter != '1 |=> link_down_flag && link_lost_counter == $past(link_lost_counter) + 1'b1;
  endproperty
  a_down: assert property (p_down) else $error("link-down not counted");
  property p_sd_loss;
    en && sd_loss |=> rx_restart_o && !rx_frame_enable_o;
  endproperty
  a_sd_loss: assert property (p_sd_loss) else $error("signal loss not acted on");
  property p_tx_flag;
    tx_o.kind == tk_lpi |-> tx_flag;
  endproperty
  a_tx_flag: assert property (p_tx_flag) else $error("idle symbol sent without flag");
  property p_wake_sat;
    wake_error_counter == '1 |=> wake_error_counter == '1;
  endproperty
  a_wake_sat: assert property (p_wake_sat) else $error("wake counter wrapped");

  c_read: cover property (rd ##1 wb_ack_o);
  c_link_ok: cover property (an_st == st_idle_detect ##1 an_st == st_link_ok);
  c_down: cover property (link_down_p);
  c_quiet: cover property (tx_serdes_stop_o);
endmodule
`default_nettype wire

/* File: gpc_link_partner.sv */
// gpc_link_partner.sv: far end of the serial link, answering pages and looping codes
// assumes the control block's tx_o on clk_i; the bench picks the words and the reply delay
`timescale 1ns/1ps
`default_nettype none
module gpc_link_partner import gpc_pkg::*; (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // bench controls
  input wire logic [15:0] base_word_i,
  input wire logic [15:0] np_word_i,
  input wire logic [3:0] delay_i,
  input wire logic pat_loop_i,
  // link
  input wire gpc_tx_t tx_i,
  output logic rx_cfg_valid_o,
  output logic [15:0] rx_cfg_word_o,
  output logic rx_code_valid_o,
  output logic [9:0] rx_code_o
);
  logic [15:0] last_word;
  logic [4:0] wait_cnt;
  logic sent_base;
  // a new page word from the device is answered once, base page first
  always_ff @(posedge clk_i) begin
    rx_cfg_valid_o <= 1'h0;
    if (rx_cfg_valid_o) begin
      rx_cfg_word_o <= ~rx_cfg_word_o;
    end
    if (rst_i) begin
      last_word <= 16'h0;
      wait_cnt <= 5'h0;
      sent_base <= 1'h0;
      rx_cfg_word_o <= 16'hffff;
    end else if (tx_i.kind != tk_cfg || tx_i.word == 16'h0) begin
      last_word <= 16'h0;
      wait_cnt <= 5'h0;
      sent_base <= 1'h0;
    end else if (tx_i.word != last_word) begin
      last_word <= tx_i.word;
      wait_cnt <= {1'h0, delay_i} + 5'h1;
    end else if (wait_cnt == 5'h1) begin
      wait_cnt <= 5'h0;
      rx_cfg_valid_o <= 1'h1;
      rx_cfg_word_o <= sent_base ? np_word_i : base_word_i;
      sent_base <= 1'h1;
    end else if (wait_cnt != 5'h0) begin
      wait_cnt <= wait_cnt - 5'h1;
    end
  end
  // pattern code groups come back, inverted unless looped
  always_comb begin
    rx_code_valid_o = tx_i.kind == tk_pattern;
    rx_code_o = pat_loop_i ? tx_i.word[9:0] : ~tx_i.word[9:0];
  end
endmodule
`default_nettype wire

/* File: gigabit_pcs_control_tb.sv */
// gigabit_pcs_control_tb.sv: register-level bench of the 1G PCS control block
// assumes the link partner model and short link timers of 20 and 40 cycles
`timescale 1ns/1ps
`default_nettype none
`include "gpc_defs.svh"
module gigabit_pcs_control_tb import gpc_pkg::*;;
  logic clk_i = 1'h0, rst_i = 1'h1, cyc = 1'h0, stb = 1'h0, we = 1'h0;
  logic [7:0] adr = 8'h0;
  logic [3:0] sel = 4'h0;
  logic [31:0] wdat = 32'h0, rdat, wb_dat_o, c0;
  logic rx_sync_i = 1'h0, rx_lpi_i = 1'h0, sd_pma_i = 1'h1, sd_pmd_i = 1'h0, mac_tx_lpi_i = 1'h0;
  logic pat_loop = 1'h0, wb_ack_o, cfg_v, code_v, tx_de, stop, loop_o, rx_restart_o, rx_frame_enable_o, link_o;
  logic [15:0] cfg_w;
  logic [9:0] code;
  logic [15:0] base_w = 16'hc1a0, np_w = 16'h0456;
  logic [3:0] dly = 4'h3, bsel = 4'hf;
  gpc_tx_t tx_o;
  int errors = 0, cmp_count = 0;
  always #25 clk_i = ~clk_i;
  gpc_pcs_ctrl #(.P_LT_SGMII_CYC(20), .P_LT_SERDES_CYC(40), .P_QUIET_CYC(4), .P_REFRESH_CYC(2)) i_dut (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(sel), .wb_dat_i(wdat), .wb_ack_o(wb_ack_o), .wb_dat_o(wb_dat_o), .rx_sync_i(rx_sync_i),
    .rx_cfg_valid_i(cfg_v), .rx_cfg_word_i(cfg_w), .rx_lpi_i(rx_lpi_i), .rx_code_valid_i(code_v),
    .rx_code_i(code), .sd_pma_i(sd_pma_i), .sd_pmd_i(sd_pmd_i), .mac_tx_lpi_i(mac_tx_lpi_i), .tx_o(tx_o),
    .tx_data_enable_o(tx_de), .tx_serdes_stop_o(stop), .loop_o(loop_o), .rx_restart_o(rx_restart_o),
    .rx_frame_enable_o(rx_frame_enable_o), .link_o(link_o));
  gpc_link_partner i_partner (.clk_i(clk_i), .rst_i(rst_i), .base_word_i(base_w), .np_word_i(np_w),
    .delay_i(dly), .pat_loop_i(pat_loop), .tx_i(tx_o), .rx_cfg_valid_o(cfg_v), .rx_cfg_word_o(cfg_w),
    .rx_code_valid_o(code_v), .rx_code_o(code));
  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      errors++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc <= 1'h1;
    stb <= 1'h1;
    we <= w;
    adr <= a;
    sel <= bsel;
    wdat <= d;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'h1 && n < 50);
    rdat = wb_dat_o;
    cyc <= 1'h0;
    stb <= 1'h0;
    we <= 1'h0;
    if (n >= 50) begin
      errors++;
      $display("wrong value bus ack expected 1 seen 0");
    end
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    bus(1'h0, a, 32'h0);
    chk($sformatf("register %h", a), e, rdat & m);
  endtask
  task automatic poll(input logic [7:0] a, input logic [31:0] m);
    int n;
    n = 0;
    do begin
      bus(1'h0, a, 32'h0);
      n++;
    end while ((rdat & m) === 32'h0 && n < 300);
    if ((rdat & m) === 32'h0) begin
      errors++;
      $display("wrong value poll %h expected nonzero seen %h", a, rdat & m);
    end
  endtask
  initial begin
    #1000000;
    errors++;
    tally_and_finish();
  end
  initial begin
    int n;
    repeat (20) @(posedge clk_i);
    rst_i <= 1'h0;
    rd(`GPC_REG_CFG, 32'hffffffff, `GPC_CFG_RST);
    rd(`GPC_REG_SD, 32'hffffffff, `GPC_SD_RST);
    rd(`GPC_REG_AN_CFG, 32'hffffffff, `GPC_AN_RST);
    rd(8'h3c, 32'hffffffff, 32'h0);
    bsel = 4'h0;
    bus(1'h1, `GPC_REG_CFG, 32'hd);
    bsel = 4'hf;
    rd(`GPC_REG_CFG, 32'hffffffff, `GPC_CFG_RST);
    bus(1'h1, `GPC_REG_CFG, 32'hd);
    repeat (4) @(posedge clk_i);
    chk("one way data", 32'h1, tx_de);
    chk("loopback", 32'h1, loop_o);
    bus(1'h1, `GPC_REG_CFG, 32'h0);
    repeat (4) @(posedge clk_i);
    chk("disabled data", 32'h0, tx_de);
    chk("loopback off", 32'h0, loop_o);
    rx_sync_i <= 1'h1;
    bus(1'h1, `GPC_REG_CFG, 32'h1);
    bus(1'h1, `GPC_REG_AN_CFG, 32'h80200001);
    poll(`GPC_REG_AN_STAT, 32'h2);
    rd(`GPC_REG_AN_STAT, 32'hffff0002, 32'hc1a00002);
    bus(1'h1, `GPC_REG_AN_STAT, 32'h2);
    rd(`GPC_REG_AN_STAT, 32'h2, 32'h0);
    bus(1'h1, `GPC_REG_NP_CFG, 32'h01230001);
    poll(`GPC_REG_AN_STAT, 32'h4);
    rd(`GPC_REG_NP_STAT, 32'hffff, 32'h0456);
    rd(`GPC_REG_AN_STAT, 32'h7, 32'h6);
    poll(`GPC_REG_AN_STAT, 32'h1);
    rd(`GPC_REG_AN_STAT, 32'hffffffff, 32'hc1a00007);
    rd(`GPC_REG_LINK, 32'h7, 32'h7);
    chk("link", 32'h1, link_o);
    bus(1'h1, `GPC_REG_STICKY, 32'h1);
    rd(`GPC_REG_STICKY, 32'h1, 32'h0);
    bus(1'h0, `GPC_REG_DOWN_CNT, 32'h0);
    c0 = rdat;
    bus(1'h1, `GPC_REG_AN_CFG, 32'h80200003);
    rd(`GPC_REG_AN_CFG, 32'hffffffff, 32'h80200001);
    rd(`GPC_REG_AN_STAT, 32'h1, 32'h0);
    rx_sync_i <= 1'h0;
    poll(`GPC_REG_STICKY, 32'h1);
    rd(`GPC_REG_STICKY, 32'h1, 32'h1);
    rd(`GPC_REG_DOWN_CNT, 32'hffffffff, c0 + 32'h1);
    bus(1'h1, `GPC_REG_AN_CFG, 32'h80200000);
    rx_sync_i <= 1'h1;
    repeat (100) @(posedge clk_i);
    bus(1'h1, `GPC_REG_STICKY, 32'h1);
    rd(`GPC_REG_STICKY, 32'h1, 32'h0);
    bus(1'h0, `GPC_REG_DOWN_CNT, 32'h0);
    c0 = rdat;
    repeat (100) @(posedge clk_i);
    rd(`GPC_REG_DOWN_CNT, 32'hffffffff, c0);
    bus(1'h1, `GPC_REG_SD, 32'h3);
    sd_pma_i <= 1'h0;
    repeat (4) @(posedge clk_i);
    chk("rx restart", 32'h1, rx_restart_o);
    chk("frame enable", 32'h0, rx_frame_enable_o);
    bus(1'h1, `GPC_REG_SD, 32'h7);
    sd_pmd_i <= 1'h1;
    repeat (4) @(posedge clk_i);
    chk("pmd restart", 32'h0, rx_restart_o);
    chk("pmd frames", 32'h1, rx_frame_enable_o);
    rd(`GPC_REG_LINK, 32'h4, 32'h4);
    bus(1'h1, `GPC_REG_SD, 32'h6);
    sd_pmd_i <= 1'h0;
    repeat (4) @(posedge clk_i);
    chk("sd off restart", 32'h0, rx_restart_o);
    rx_sync_i <= 1'h0;
    bus(1'h0, `GPC_REG_WAKE_CNT, 32'h0);
    c0 = rdat;
    sd_pmd_i <= 1'h1;
    repeat (4) @(posedge clk_i);
    rd(`GPC_REG_WAKE_CNT, 32'hffffffff, c0 + 32'h1);
    rd(`GPC_REG_LINK, 32'h2, 32'h0);
    bus(1'h1, `GPC_REG_SD, 32'h5);
    repeat (2) @(posedge clk_i);
    chk("low polarity restart", 32'h1, rx_restart_o);
    pat_loop <= 1'h1;
    for (int i = 1; i <= 5; i++) begin
      bus(1'h1, `GPC_REG_TP_CFG, i);
      repeat (4) @(posedge clk_i);
      chk("pattern kind", tk_pattern, tx_o.kind);
    end
    repeat (40) @(posedge clk_i);
    rd(`GPC_REG_TP_STAT, 32'hff01, 32'h1);
    pat_loop <= 1'h0;
    repeat (4) @(posedge clk_i);
    rd(`GPC_REG_TP_STAT, 32'hff01, 32'h100);
    bus(1'h1, `GPC_REG_TP_CFG, 32'h0);
    repeat (4) @(posedge clk_i);
    chk("pattern off", 32'h0, tx_o.kind == tk_pattern);
    bus(1'h1, `GPC_REG_LPI_CFG, 32'h1);
    poll(`GPC_REG_LPI_STAT, 32'h8);
    rd(`GPC_REG_LPI_STAT, 32'h24, 32'h24);
    n = 0;
    while (stop !== 1'h1 && n < 100) begin
      @(posedge clk_i);
      n++;
    end
    chk("serdes stop", 32'h1, stop);
    rx_lpi_i <= 1'h1;
    @(posedge clk_i);
    rx_lpi_i <= 1'h0;
    rd(`GPC_REG_LPI_STAT, 32'h13, 32'h13);
    bus(1'h1, `GPC_REG_LPI_CFG, 32'h0);
    repeat (20) @(posedge clk_i);
    bus(1'h1, `GPC_REG_LPI_STAT, 32'h30);
    rd(`GPC_REG_LPI_STAT, 32'h34, 32'h0);
    mac_tx_lpi_i <= 1'h1;
    repeat (10) @(posedge clk_i);
    rd(`GPC_REG_LPI_STAT, 32'h4, 32'h4);
    mac_tx_lpi_i <= 1'h0;
    base_w <= 16'h4001;
    dly <= 4'h0;
    bus(1'h1, `GPC_REG_SD, 32'h2);
    rx_sync_i <= 1'h1;
    bus(1'h1, `GPC_REG_CFG, 32'h3);
    bus(1'h1, `GPC_REG_AN_CFG, 32'h00200001);
    poll(`GPC_REG_AN_STAT, 32'h4);
    repeat (24) @(posedge clk_i);
    rd(`GPC_REG_AN_STAT, 32'hffff0005, 32'h40010005);
    rd(`GPC_REG_LINK, 32'h3, 32'h2);
    tally_and_finish();
  end
endmodule
`default_nettype wire
